// file: dv/prog_mem_model.sv
// program memory model supplying instruction words to the bench
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
   import clear_exec_pkg::*;
(
   input  wire logic [1:0]  idx,   // word index
   output var  logic [15:0] word   // instruction word at that index
);
   // ***************************************************************
   // fixed program image
   // ***************************************************************
   always_comb begin
      case (idx)
         2'h0: word = OPC_CALL_WORK;
         2'h1: word = OPC_CLR_WDOG;
         default: word = 16'h0000;
      endcase
   end
endmodule // prog_mem_model
`default_nettype wire

// file: dv/test_clear_and_working_register_call_exec.sv
// self-checking testbench of the three-instruction executor
`timescale 1ns/1ps
`default_nettype none
module test_clear_and_working_register_call_exec;
   import clear_exec_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  pm_idx = 2'h0;
   logic [15:0] pm_word;
   int          err_total = 0;
   int          samples_checked = 0;
   integer      seed = 64583;

   always #12.5 clk_sys = ~clk_sys;

   clear_and_working_register_call_exec clear_and_working_register_call_exec_inst (
      .CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr));
   prog_mem_model prog_mem_model_inst (.idx(pm_idx), .word(pm_word));

   // ***************************************************************
   // bus tasks and checks
   // ***************************************************************
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // hold the request until ready is seen at a rising edge
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h00000000, r, e);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic run_op(input logic [15:0] op);
      logic [31:0] r;
      wr(OFS_INSTR, {16'h0000, op});
      do begin
         rd(OFS_INSTR, r);
      end while (r[INSTR_BUSY_BIT] !== 1'b0);
   endtask

   function automatic logic [11:0] clr_addr(logic a, logic ext,
      logic [7:0] f, logic [5:0] bank, logic [11:0] base);
      if (a)
         return {bank[3:0], f};
      if (ext && f <= ACCESS_LIMIT)
         return base + {4'h0, f};
      return (f <= ACCESS_LIMIT) ? {4'h0, f} : {ACCESS_SFR_HI, f};
   endfunction

   task conclude;
      if (err_total == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk_sys);
      err_total++;
      conclude;
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      logic [31:0] r, p, c, s, b;
      logic [7:0]  w, h, f;
      logic [4:0]  u;
      logic [5:0]  bs;
      logic [11:0] base;
      logic        a, ext, e;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(OFS_STATUS, r);
      chk(r, {27'h0, STATUS_RST});
      // call: random targets, one with full upper latch
      for (int k = 0; k < 3; k++) begin
         w = 8'($random(seed)) & 8'hFE;
         h = 8'($random(seed));
         u = (k == 0) ? 5'h1F : 5'($random(seed));
         wr(OFS_WORKING, {24'h0, w});
         wr(OFS_PC_HIGH, {24'h0, h});
         wr(OFS_PC_UPPER, {27'h0, u});
         wr(OFS_BANK_SEL, 32'($random(seed)) & 32'h3F);
         wr(OFS_PC, 32'($random(seed)) & 32'h001FFFFE);
         rd(OFS_PC, p);
         rd(OFS_STACK_CNT, c);
         rd(OFS_STATUS, s);
         rd(OFS_BANK_SEL, b);
         pm_idx <= 2'h0;
         @(posedge clk_sys);
         run_op(pm_word);
         rd(OFS_PC, r);
         chk(r, {11'h0, u, h, w});
         rd(OFS_STACK_TOP, r);
         chk(r, (p + 32'(PC_STEP)) & 32'h001FFFFF);
         rd(OFS_STACK_CNT, r);
         chk(r, c + 32'h1);
         rd(OFS_STATUS, r);
         chk(r, s);
         rd(OFS_WORKING, r);
         chk(r, {24'h0, w});
         rd(OFS_BANK_SEL, r);
         chk(r, b);
      end
      // clear-file over bank bit, extended set and field boundaries
      for (int k = 0; k < 12; k++) begin
         a = k[0];
         ext = k[1];
         f = (k < 4) ? 8'h5F : (k < 8) ? 8'h60 : 8'($random(seed));
         bs = 6'($random(seed));
         base = 12'($random(seed));
         wr(OFS_CTRL, {31'h0, ext});
         wr(OFS_BANK_SEL, {26'h0, bs});
         wr(OFS_INDEX_BASE, {20'h0, base});
         wr(OFS_MEM_ADDR, {20'h0, clr_addr(a, ext, f, bs, base)});
         wr(OFS_MEM_DATA, 32'h000000A5);
         rd(OFS_MEM_DATA, r);
         chk(r, 32'h000000A5);
         wr(OFS_STATUS, {27'h0, STATUS_RST});
         run_op({OPC_FCLR_HI, a, f});
         rd(OFS_MEM_DATA, r);
         chk(r, 32'h00000000);
         rd(OFS_STATUS, r);
         chk(r, {27'h0, STATUS_RST} | 32'h4);
      end
      // watchdog clear after the counter has run
      wr(OFS_CTRL, 32'h00000002);
      repeat (80) @(posedge clk_sys);
      wr(OFS_CTRL, 32'h00000000);
      rd(OFS_WATCHDOG, r);
      chk(32'(r != 32'h0), 32'h1);
      wr(OFS_STATUS, 32'h00000000);
      pm_idx <= 2'h1;
      @(posedge clk_sys);
      run_op(pm_word);
      rd(OFS_WATCHDOG, r);
      chk(r, 32'h00000000);
      rd(OFS_STATUS, r);
      chk(r, {27'h0, STATUS_RST});
      // unmapped address and read-only stack top
      apb(1'b1, 12'hFF0, $random(seed), r, e);
      chk({31'h0, e}, 32'h1);
      apb(1'b0, 12'hFF0, 32'h0, r, e);
      chk(r, 32'h0);
      rd(OFS_STACK_TOP, p);
      wr(OFS_STACK_TOP, ~p);
      rd(OFS_STACK_TOP, r);
      chk(r, p);
      conclude;
   end
endmodule // test_clear_and_working_register_call_exec
`default_nettype wire

// file: verilog/clear_and_working_register_call_exec.sv
// executor for call-via-working-register, clear-file and clear-watchdog
//
// Contract
// - call loads pc from upper latch, high latch, working register
// - call pushes its own address plus two onto stack top
// - clear-file opcode 0110 101a ffff ffff writes zero, sets zero flag
// - bank bit 0 selects access bank, 1 uses bank select register
// - bank bit 0 with extended set: field up to 5Fh is indexed
// - opcode 0000 0000 0000 0100 zeroes watchdog in one cycle
// - watchdog clear sets timeout and powerdown flags to one
// - call takes two cycles, second a no-operation, no shadowing
// - opcode 0000 0000 0001 0100 is the call, touches no flags
`timescale 1ns/1ps
`default_nettype none
module clear_and_working_register_call_exec
   import clear_exec_pkg::*;
(
   input  wire logic        CLK_SYS,  // 40 MHz core clock
   input  wire logic        RSTN,     // synchronous reset, active low
   input  wire logic        PSEL,     // apb select
   input  wire logic        PENABLE,  // apb access phase
   input  wire logic        PWRITE,   // apb direction
   input  wire logic [11:0] PADDR,    // apb byte address
   input  wire logic [31:0] PWDATA,   // apb write data
   output var  logic [31:0] PRDATA,   // apb read data
   output var  logic        PREADY,   // apb ready
   output var  logic        PSLVERR   // apb error, unmapped address
);

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   function automatic logic is_call_work(input logic [15:0] i);
      return i == OPC_CALL_WORK;
   endfunction

   function automatic logic is_clr_wdog(input logic [15:0] i);
      return i == OPC_CLR_WDOG;
   endfunction

   function automatic logic is_fclr(input logic [15:0] i);
      return i[15:9] == OPC_FCLR_HI;
   endfunction

   function automatic logic [DMEM_AW-1:0] fclr_target(
      input logic [15:0]        i,
      input logic [5:0]         bank,
      input logic               ext,
      input logic [DMEM_AW-1:0] base);
      logic [13:0] banked;
      banked = {bank, i[7:0]};
      if (i[8]) begin
         return banked[DMEM_AW-1:0];
      end
      if (ext && i[7:0] <= ACCESS_LIMIT) begin
         return base + {4'h0, i[7:0]};
      end else if (i[7:0] <= ACCESS_LIMIT) begin
         return {4'h0, i[7:0]};
      end else begin
         return {ACCESS_SFR_HI, i[7:0]};
      end
   endfunction

   core_state_t        r_reg;
   core_state_t        r_next;
   mem_wr_t            mem_wr;
   logic [DMEM_DW-1:0] mem_rdata;
   logic               busy;
   logic               setup;
   logic               acc_wr;
   logic               clr_fire;
   logic [31:0]        rd_val;
   logic               rd_ok;

   dmem_store u_dmem (
      .CLK_SYS (CLK_SYS),
      .wr      (mem_wr),
      .raddr   (r_reg.mem_addr),
      .rdata   (mem_rdata)
   );

   // ***************************************************************
   // bus handshake and memory port
   // ***************************************************************
   assign busy     = r_reg.pending || (r_reg.st != ST_IDLE);
   assign clr_fire = (r_reg.st == ST_EXEC) && (r_reg.q == Q_LAST)
                     && is_fclr(r_reg.instr);
   assign setup    = PSEL && !PENABLE;

   always_comb begin
      PREADY = 1'b1;
      if (PSEL && PENABLE && PWRITE) begin
         if (PADDR == OFS_INSTR && busy) begin
            PREADY = 1'b0;
         end
         if (PADDR == OFS_MEM_DATA && clr_fire) begin
            PREADY = 1'b0;
         end
      end
   end

   assign acc_wr  = PSEL && PENABLE && PWRITE && PREADY;
   assign PRDATA  = r_reg.prdata;
   assign PSLVERR = PSEL && PENABLE && r_reg.pslverr;

   always_comb begin
      mem_wr = '0;
      if (clr_fire) begin
         mem_wr.we   = 1'b1;
         mem_wr.addr = fclr_target(r_reg.instr, r_reg.bank_sel, r_reg.ext_en,
                                   r_reg.index_base);
         mem_wr.data = '0;
      end else if (acc_wr && PADDR == OFS_MEM_DATA) begin
         mem_wr.we   = 1'b1;
         mem_wr.addr = r_reg.mem_addr;
         mem_wr.data = PWDATA[DMEM_DW-1:0];
      end
   end

   always_comb begin
      rd_ok  = 1'b1;
      rd_val = '0;
      case (PADDR)
         OFS_CTRL:       rd_val = {30'h0, r_reg.wdog_en, r_reg.ext_en};
         OFS_INSTR:      rd_val = {15'h0, busy, r_reg.instr};
         OFS_WORKING:    rd_val = {24'h0, r_reg.working};
         OFS_BANK_SEL:   rd_val = {26'h0, r_reg.bank_sel};
         OFS_PC_HIGH:    rd_val = {24'h0, r_reg.pc_high};
         OFS_PC_UPPER:   rd_val = {27'h0, r_reg.pc_upper};
         OFS_PC:         rd_val = {11'h0, r_reg.pc};
         OFS_STACK_TOP:  rd_val = {11'h0, r_reg.stack_top};
         OFS_STATUS:     rd_val = {27'h0, r_reg.status};
         OFS_WATCHDOG:   rd_val = {24'h0, r_reg.wdog};
         OFS_INDEX_BASE: rd_val = {20'h0, r_reg.index_base};
         OFS_MEM_ADDR:   rd_val = {20'h0, r_reg.mem_addr};
         OFS_MEM_DATA:   rd_val = {24'h0, mem_rdata};
         OFS_STACK_CNT:  rd_val = {27'h0, r_reg.stack_cnt};
         default:        rd_ok  = 1'b0;
      endcase
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      r_next   = r_reg;
      r_next.q = r_reg.q + 2'h1;
      if (setup) begin
         r_next.prdata  = rd_val;
         r_next.pslverr = !rd_ok;
      end
      if (acc_wr) begin
         case (PADDR)
            OFS_CTRL: begin
               r_next.ext_en  = PWDATA[CTRL_EXT_BIT];
               r_next.wdog_en = PWDATA[CTRL_WDOG_BIT];
            end
            OFS_INSTR: begin
               r_next.instr   = PWDATA[15:0];
               r_next.pending = 1'b1;
            end
            OFS_WORKING:    r_next.working    = PWDATA[7:0];
            OFS_BANK_SEL:   r_next.bank_sel   = PWDATA[5:0];
            OFS_PC_HIGH:    r_next.pc_high    = PWDATA[7:0];
            OFS_PC_UPPER:   r_next.pc_upper   = PWDATA[4:0];
            OFS_PC:         r_next.pc         = {PWDATA[20:1], 1'b0};
            OFS_STATUS:     r_next.status     = PWDATA[4:0];
            OFS_INDEX_BASE: r_next.index_base = PWDATA[DMEM_AW-1:0];
            OFS_MEM_ADDR:   r_next.mem_addr   = PWDATA[DMEM_AW-1:0];
            default: ;
         endcase
      end
      // watchdog ticks once per instruction cycle
      if (r_reg.wdog_en && r_reg.q == Q_LAST
          && !(r_reg.st == ST_EXEC && is_clr_wdog(r_reg.instr))) begin
         r_next.wdog = r_reg.wdog + 1'b1;
         if (&r_reg.wdog) begin
            r_next.status[ST_TO_BIT] = 1'b0;
         end
      end
      case (r_reg.st)
         ST_IDLE: begin
            if (r_reg.pending && r_reg.q == Q_LAST) begin
               r_next.st      = ST_EXEC;
               r_next.pending = 1'b0;
            end
         end
         ST_EXEC: begin
            if (r_reg.q == Q_PROC) begin
               if (is_call_work(r_reg.instr)) begin
                  r_next.stack_top = r_reg.pc + PC_STEP;
                  if (r_reg.stack_cnt != STACK_MAX) begin
                     r_next.stack_cnt = r_reg.stack_cnt + 5'h1;
                  end
               end
               if (is_clr_wdog(r_reg.instr)) begin
                  r_next.wdog = '0;
                  r_next.status[ST_TO_BIT]    = 1'b1;
                  r_next.status[ST_PWRDN_BIT] = 1'b1;
               end
            end
            if (r_reg.q == Q_LAST) begin
               if (is_call_work(r_reg.instr)) begin
                  r_next.pc = {r_reg.pc_upper, r_reg.pc_high, r_reg.working};
                  r_next.st = ST_NOP2;
               end else begin
                  r_next.pc = r_reg.pc + PC_STEP;
                  r_next.st = ST_IDLE;
               end
               if (clr_fire) begin
                  r_next.status[ST_Z_BIT] = 1'b1;
               end
            end
         end
         ST_NOP2: begin
            if (r_reg.q == Q_LAST) begin
               r_next.st = ST_IDLE;
            end
         end
         default: r_next.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         r_reg        <= '0;
         r_reg.st     <= ST_IDLE;
         r_reg.status <= STATUS_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);

   logic call_wr;
   logic call_push;
   logic wdog_clr;
   assign call_wr   = r_reg.st == ST_EXEC && r_reg.q == Q_LAST
                      && is_call_work(r_reg.instr);
   assign call_push = r_reg.st == ST_EXEC && r_reg.q == Q_PROC
                      && is_call_work(r_reg.instr);
   assign wdog_clr  = r_reg.st == ST_EXEC && r_reg.q == Q_PROC
                      && is_clr_wdog(r_reg.instr);

   a_call_pc_load: assert property (
      call_wr |=> r_reg.pc == {$past(r_reg.pc_upper), $past(r_reg.pc_high),
                               $past(r_reg.working)})
      else $error("call did not load pc from latches");
   a_call_push_ret: assert property (
      call_push |=> r_reg.stack_top == $past(r_reg.pc) + PC_STEP)
      else $error("call pushed wrong return address");
   a_fclr_write_zero: assert property (
      clr_fire |-> mem_wr.we && mem_wr.data == '0
                   ##1 r_reg.status[ST_Z_BIT])
      else $error("clear did not zero register or set zero flag");
   a_fclr_bank_addr: assert property (
      clr_fire && r_reg.instr[8]
      |-> mem_wr.addr == {r_reg.bank_sel[3:0], r_reg.instr[7:0]})
      else $error("banked clear used wrong address");
   a_fclr_indexed_addr: assert property (
      clr_fire && !r_reg.instr[8] && r_reg.ext_en
      && r_reg.instr[7:0] <= ACCESS_LIMIT
      |-> mem_wr.addr == r_reg.index_base + {4'h0, r_reg.instr[7:0]})
      else $error("indexed clear used wrong address");
   a_wdog_count_zero: assert property (
      wdog_clr |=> r_reg.wdog == '0 ##1 r_reg.wdog == '0)
      else $error("watchdog not zeroed");
   a_wdog_flags_set: assert property (
      wdog_clr |=> r_reg.status[ST_TO_BIT] && r_reg.status[ST_PWRDN_BIT])
      else $error("timeout or powerdown flag not set");
   a_call_two_cycles: assert property (
      call_wr |=> (r_reg.st == ST_NOP2)[*4] ##1 r_reg.st == ST_IDLE)
      else $error("call second cycle length wrong");
   a_call_no_flags: assert property (
      call_wr |=> $stable(r_reg.status[ST_Z_BIT]))
      else $error("call changed zero flag");

   c_call_done: cover property (call_wr ##5 r_reg.st == ST_IDLE);
   c_fclr_banked: cover property (clr_fire && r_reg.instr[8]);
   c_fclr_indexed: cover property (clr_fire && r_reg.ext_en
                                   && !r_reg.instr[8]);
   c_wdog_run: cover property (wdog_clr);

endmodule // clear_and_working_register_call_exec
`default_nettype wire

// file: verilog/clear_exec_pkg.sv
// package: constants, register map and carrier types of the executor
package clear_exec_pkg;

   // ***************************************************************
   // register map (byte addresses)
   // ***************************************************************
   localparam logic [11:0] OFS_CTRL       = 12'h000;
   localparam logic [11:0] OFS_INSTR      = 12'h004;
   localparam logic [11:0] OFS_WORKING    = 12'h008;
   localparam logic [11:0] OFS_BANK_SEL   = 12'h00C;
   localparam logic [11:0] OFS_PC_HIGH    = 12'h010;
   localparam logic [11:0] OFS_PC_UPPER   = 12'h014;
   localparam logic [11:0] OFS_PC         = 12'h018;
   localparam logic [11:0] OFS_STACK_TOP  = 12'h01C;
   localparam logic [11:0] OFS_STATUS     = 12'h020;
   localparam logic [11:0] OFS_WATCHDOG   = 12'h024;
   localparam logic [11:0] OFS_INDEX_BASE = 12'h028;
   localparam logic [11:0] OFS_MEM_ADDR   = 12'h02C;
   localparam logic [11:0] OFS_MEM_DATA   = 12'h030;
   localparam logic [11:0] OFS_STACK_CNT  = 12'h034;

   // ***************************************************************
   // fields, reset values, encodings
   // ***************************************************************
   localparam int          CTRL_EXT_BIT   = 0;
   localparam int          CTRL_WDOG_BIT  = 1;
   localparam int          INSTR_BUSY_BIT = 16;
   localparam int          ST_Z_BIT       = 2;
   localparam int          ST_PWRDN_BIT   = 3;
   localparam int          ST_TO_BIT      = 4;
   localparam logic [4:0]  STATUS_RST     = 5'h18;
   localparam logic [15:0] OPC_CALL_WORK  = 16'h0014;
   localparam logic [15:0] OPC_CLR_WDOG   = 16'h0004;
   localparam logic [6:0]  OPC_FCLR_HI    = 7'h35;
   localparam logic [7:0]  ACCESS_LIMIT   = 8'h5F;
   localparam logic [3:0]  ACCESS_SFR_HI  = 4'hF;
   localparam logic [20:0] PC_STEP        = 21'h000002;
   localparam logic [4:0]  STACK_MAX      = 5'h1F;
   localparam int          WDOG_BITS      = 8;
   localparam int          DMEM_AW        = 12;
   localparam int          DMEM_DW        = 8;

   // ***************************************************************
   // timing: four clock phases per instruction cycle
   // ***************************************************************
   localparam logic [1:0]  Q_PROC         = 2'h2;
   localparam logic [1:0]  Q_LAST         = 2'h3;

   typedef enum {ST_IDLE, ST_EXEC, ST_NOP2} seq_state_t;

   typedef struct packed {
      logic               we;
      logic [DMEM_AW-1:0] addr;
      logic [DMEM_DW-1:0] data;
   } mem_wr_t;

   typedef struct packed {
      seq_state_t           st;
      logic [1:0]           q;
      logic [15:0]          instr;
      logic                 pending;
      logic                 ext_en;
      logic                 wdog_en;
      logic [7:0]           working;
      logic [5:0]           bank_sel;
      logic [7:0]           pc_high;
      logic [4:0]           pc_upper;
      logic [20:0]          pc;
      logic [20:0]          stack_top;
      logic [4:0]           stack_cnt;
      logic [4:0]           status;
      logic [WDOG_BITS-1:0] wdog;
      logic [DMEM_AW-1:0]   index_base;
      logic [DMEM_AW-1:0]   mem_addr;
      logic [31:0]          prdata;
      logic                 pslverr;
   } core_state_t;

endpackage

// file: verilog/dmem_store.sv
// data memory: one write port, registered read port
`timescale 1ns/1ps
`default_nettype none
module dmem_store
   import clear_exec_pkg::*;
(
   input  wire logic               CLK_SYS,  // system clock
   input  wire mem_wr_t            wr,       // write request
   input  wire logic [DMEM_AW-1:0] raddr,    // read address
   output var  logic [DMEM_DW-1:0] rdata     // registered read data
);
   logic [DMEM_DW-1:0] mem [0:(1<<DMEM_AW)-1];

   always_ff @(posedge CLK_SYS) begin
      if (wr.we) begin
         mem[wr.addr] <= wr.data;
      end
      rdata <= mem[raddr];
   end
endmodule // dmem_store
`default_nettype wire
